// file: rtl/rtcs_pkg.sv
// Shared constants and types of the RTC serial slave
package rtcs_pkg;

  // ----------------------------------------------------------------
  // Slave identifiers and pointer limits
  // ----------------------------------------------------------------
  localparam logic [6:0] RTCS_ID_CSR    = 7'h6F;
  localparam logic [6:0] RTCS_ID_SRAM   = 7'h57;
  localparam logic [7:0] RTCS_CSR_WRAP  = 8'h13;
  localparam logic [7:0] RTCS_SRAM_WRAP = 8'h7F;
  localparam logic [7:0] RTCS_PTR_RST   = 8'h00;
  localparam logic [7:0] RTCS_PTR_STEP  = 8'h01;

  // ----------------------------------------------------------------
  // Bit counting and buffering
  // ----------------------------------------------------------------
  localparam logic [3:0] RTCS_BYTE_BITS  = 4'h8;
  localparam logic [3:0] RTCS_CNT_RST    = 4'h0;
  localparam logic [3:0] RTCS_CNT_STEP   = 4'h1;
  localparam int         RTCS_FIFO_DEPTH = 4;
  localparam int         RTCS_SYNC_W     = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_ADDR   = 4'h1,
    ST_WADDR  = 4'h2,
    ST_WDATA  = 4'h3,
    ST_ACK    = 4'h4,
    ST_RDATA  = 4'h5,
    ST_RACK   = 4'h6,
    ST_IGNORE = 4'h7
  } rtcs_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } rtcs_ev_type;

  typedef struct packed {
    logic       sram;
    logic [7:0] addr;
    logic [7:0] data;
  } rtcs_wr_type;

endpackage : rtcs_pkg

// file: rtl/rtcs_pin_sync.sv
// Two-flop synchroniser and bus condition detector for the serial pins
`timescale 1ns/100ps
module rtcs_pin_sync
  import rtcs_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  // Events
  output rtcs_ev_type      o_ev
);

  logic [RTCS_SYNC_W-1:0] meta_r;
  logic [RTCS_SYNC_W-1:0] sync_r;
  logic [RTCS_SYNC_W-1:0] prev_r;
  logic [RTCS_SYNC_W-1:0] pin_in;

  assign pin_in = {i_scl, i_sda};

  // ----------------------------------------------------------------
  // Per-pin stages; idle lines are high
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < RTCS_SYNC_W; g++) begin : g_pin
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
          prev_r[g] <= 1'b1;
        end else begin
          meta_r[g] <= pin_in[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
        end
      end
    end
  endgenerate

  // Only the second and third stages feed logic
  assign o_ev.scl      = sync_r[1];
  assign o_ev.sda      = sync_r[0];
  assign o_ev.scl_rise = sync_r[1] & ~prev_r[1];
  assign o_ev.scl_fall = ~sync_r[1] & prev_r[1];
  assign o_ev.start    = sync_r[1] & prev_r[1] & prev_r[0] & ~sync_r[0];
  assign o_ev.stop     = sync_r[1] & prev_r[1] & ~prev_r[0] & sync_r[0];

endmodule : rtcs_pin_sync

// file: rtl/rtcs_fifo.sv
// Small flop-based FIFO with valid/ready on both sides
`timescale 1ns/100ps
module rtcs_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem_r[rd_r];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
      if (pop) rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : rtcs_fifo

// file: rtl/rtcs_slave.sv
// Byte-level transaction engine of the RTC serial slave
// Contract
// - Device acknowledges address, word address and data byte of a write.
// - After a completed write the interface returns to standby awaiting START.
// - Device acknowledges every instruction byte (three in a random read, one in a current-address read) before driving any data.
// - Device keeps sending bytes while master acknowledges after each eighth bit.
// - Pointer loads from word address and increments once per transmitted byte.
// - Pointer at 13h (clock registers) or 7Fh (SRAM) wraps to 00h; data continues for every acknowledge.
// - Only identifiers 1101111 (clock registers) and 1010111 (SRAM) are acknowledged.
// - Pointer clears to 00h at power-up.
// - Every byte travels most significant bit first.
`timescale 1ns/100ps
module rtcs_slave
  import rtcs_pkg::*;
#(
  parameter int FIFO_DEPTH = RTCS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Serial pins, open drain
  input  wire logic        i_scl,
  output logic             o_scl_out,
  output logic             o_scl_oe,
  input  wire logic        i_sda_in,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  // Read data fetch
  output logic             o_rd_sram,
  output logic [7:0]       o_rd_addr,
  input  wire logic [7:0]  i_rd_data,
  output logic             o_rd_strobe,
  // Write stream
  output logic             o_wr_valid,
  input  wire logic        i_wr_ready,
  output rtcs_wr_type      o_wr,
  // Status
  output logic             o_busy
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rtcs_ev_type    ev;
  rtcs_state_type state_r, state_nxt;
  rtcs_state_type after_r, after_nxt;
  logic [3:0]     cnt_r, cnt_nxt;
  logic [7:0]     sh_r, sh_nxt;
  logic [7:0]     ptr_r, ptr_nxt;
  logic [7:0]     waddr_r, waddr_nxt;
  logic           sda_oe_r, sda_oe_nxt;
  logic           sram_r, sram_nxt;
  logic           pend_r, pend_nxt;
  logic           mack_r, mack_nxt;
  logic           strobe_r;
  logic           rx_state;
  logic           rx_done;
  logic           id_csr;
  logic           id_sram;
  logic           id_match;
  logic           at_wrap;
  logic [7:0]     ptr_inc;
  logic           load_byte;
  logic           fifo_ready;
  logic           push;
  rtcs_wr_type    wr_entry;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  rtcs_pin_sync u_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_scl  (i_scl),
    .i_sda  (i_sda_in),
    .o_ev   (ev)
  );

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  assign wr_entry.sram = sram_r;
  assign wr_entry.addr = waddr_r;
  assign wr_entry.data = sh_r;
  assign push          = pend_r & (state_r == ST_ACK);

  rtcs_fifo #(
    .WIDTH ($bits(rtcs_wr_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (wr_entry),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (o_wr)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign rx_state  = (state_r == ST_ADDR) | (state_r == ST_WADDR) | (state_r == ST_WDATA);
  assign rx_done   = (cnt_r == RTCS_BYTE_BITS);
  assign id_csr    = (sh_r[7:1] == RTCS_ID_CSR);
  assign id_sram   = (sh_r[7:1] == RTCS_ID_SRAM);
  assign id_match  = id_csr | id_sram;
  assign at_wrap   = (ptr_r == (sram_r ? RTCS_SRAM_WRAP : RTCS_CSR_WRAP));
  assign ptr_inc   = at_wrap ? RTCS_PTR_RST : ptr_r + RTCS_PTR_STEP;
  // Next byte is fetched after the instruction or on a master acknowledge
  assign load_byte = ev.scl_fall & ~ev.start & ~ev.stop &
                     (((state_r == ST_ACK) & (after_r == ST_RDATA)) |
                      ((state_r == ST_RACK) & mack_r));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    after_nxt  = after_r;
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    ptr_nxt    = ptr_r;
    waddr_nxt  = waddr_r;
    sda_oe_nxt = sda_oe_r;
    sram_nxt   = sram_r;
    pend_nxt   = pend_r;
    mack_nxt   = mack_r;
    if (ev.start) begin
      state_nxt  = ST_ADDR;
      cnt_nxt    = RTCS_CNT_RST;
      sda_oe_nxt = 1'b0;
      pend_nxt   = 1'b0;
    end else if (ev.stop) begin
      state_nxt  = ST_IDLE;
      sda_oe_nxt = 1'b0;
      pend_nxt   = 1'b0;
    end else if (load_byte) begin
      sh_nxt     = i_rd_data;
      sda_oe_nxt = ~i_rd_data[7];
      ptr_nxt    = ptr_inc;
      cnt_nxt    = RTCS_CNT_RST;
      state_nxt  = ST_RDATA;
    end else begin
      case (state_r)
        ST_ADDR, ST_WADDR, ST_WDATA: begin
          if (ev.scl_rise && !rx_done) begin
            sh_nxt  = {sh_r[6:0], ev.sda};
            cnt_nxt = cnt_r + RTCS_CNT_STEP;
          end else if (ev.scl_fall && rx_done) begin
            state_nxt  = ST_ACK;
            sda_oe_nxt = 1'b1;
            cnt_nxt    = RTCS_CNT_RST;
            if (state_r == ST_ADDR) begin
              if (!id_match) begin
                state_nxt  = ST_IGNORE;
                sda_oe_nxt = 1'b0;
              end else begin
                sram_nxt  = id_sram;
                after_nxt = sh_r[0] ? ST_RDATA : ST_WADDR;
              end
            end else if (state_r == ST_WADDR) begin
              waddr_nxt = sh_r;
              ptr_nxt   = sh_r;
              after_nxt = ST_WDATA;
            end else begin
              pend_nxt  = 1'b1;
              after_nxt = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (pend_r && fifo_ready) begin
            pend_nxt = 1'b0;
          end
          if (ev.scl_fall) begin
            sda_oe_nxt = 1'b0;
            state_nxt  = after_r;
          end
        end
        ST_RDATA: begin
          if (ev.scl_rise) begin
            cnt_nxt = cnt_r + RTCS_CNT_STEP;
          end else if (ev.scl_fall) begin
            if (rx_done) begin
              sda_oe_nxt = 1'b0;
              state_nxt  = ST_RACK;
            end else begin
              sh_nxt     = {sh_r[6:0], 1'b0};
              sda_oe_nxt = ~sh_r[6];
            end
          end
        end
        ST_RACK: begin
          if (ev.scl_rise) begin
            mack_nxt = ~ev.sda;
          end else if (ev.scl_fall) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_oe_nxt = 1'b0;
        end
        default: begin
          state_nxt  = ST_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r  <= ST_IDLE;
      after_r  <= ST_IDLE;
      cnt_r    <= RTCS_CNT_RST;
      sh_r     <= 8'h00;
      ptr_r    <= RTCS_PTR_RST;
      waddr_r  <= 8'h00;
      sda_oe_r <= 1'b0;
      sram_r   <= 1'b0;
      pend_r   <= 1'b0;
      mack_r   <= 1'b0;
      strobe_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      after_r  <= after_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      ptr_r    <= ptr_nxt;
      waddr_r  <= waddr_nxt;
      sda_oe_r <= sda_oe_nxt;
      sram_r   <= sram_nxt;
      pend_r   <= pend_nxt;
      mack_r   <= mack_nxt;
      strobe_r <= load_byte;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Full buffer stretches the data acknowledge low instead of dropping the byte
  assign o_scl_oe    = pend_r & ~fifo_ready & (state_r == ST_ACK);
  assign o_scl_out   = 1'b0;
  assign o_sda_out   = 1'b0;
  assign o_sda_oe    = sda_oe_r;
  assign o_rd_sram   = sram_r;
  assign o_rd_addr   = ptr_r;
  assign o_rd_strobe = strobe_r;
  assign o_busy      = (state_r != ST_IDLE) & (state_r != ST_IGNORE);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_addr_end_ok;
    (state_r == ST_ADDR) && ev.scl_fall && rx_done && id_match && !ev.start && !ev.stop;
  endsequence

  sequence s_write_done;
    (state_r == ST_ACK) && (after_r == ST_IDLE) && ev.scl_fall && !ev.start && !ev.stop;
  endsequence

  sequence s_master_ack;
    (state_r == ST_RACK) && mack_r && ev.scl_fall && !ev.start && !ev.stop;
  endsequence

  a_addr_ack_drive: assert property (s_addr_end_ok |=> sda_oe_r && (state_r == ST_ACK))
    else $error("matched address not acknowledged");

  a_nomatch_quiet: assert property (
    ((state_r == ST_ADDR) && ev.scl_fall && rx_done && !id_match && !ev.start && !ev.stop)
      |=> (state_r == ST_IGNORE) && !sda_oe_r)
    else $error("unmatched address drew a response");

  a_ignore_released: assert property ((state_r == ST_IGNORE) |-> !o_sda_oe && !o_busy)
    else $error("SDA driven while ignoring");

  a_write_standby: assert property (s_write_done |=> (state_r == ST_IDLE) && !sda_oe_r)
    else $error("write did not return to standby");

  a_read_continue: assert property (s_master_ack |=> (state_r == ST_RDATA) && o_rd_strobe ##1 !o_rd_strobe)
    else $error("read not continued after master acknowledge");

  a_ptr_wrap_csr: assert property (
    (load_byte && !sram_r && (ptr_r == RTCS_CSR_WRAP)) |=> (ptr_r == RTCS_PTR_RST) && o_rd_strobe)
    else $error("pointer did not wrap at 13h");

  a_ptr_step: assert property (load_byte && !at_wrap |=> ptr_r == $past(ptr_r) + RTCS_PTR_STEP)
    else $error("pointer did not step by one");

  a_ptr_from_waddr: assert property (
    ((state_r == ST_WADDR) && ev.scl_fall && rx_done && !ev.start && !ev.stop) |=> ptr_r == $past(sh_r))
    else $error("pointer not loaded from word address");

  a_msb_first: assert property (load_byte |=> sda_oe_r == !$past(i_rd_data[7]))
    else $error("first data bit is not the MSB");

  a_reset_ptr: assert property ($fell(i_srst) |-> ptr_r == RTCS_PTR_RST)
    else $error("pointer not cleared by reset");

  a_stall_hold_ack: assert property (o_scl_oe |-> sda_oe_r && (state_r == ST_ACK))
    else $error("stretch without acknowledge held");

endmodule : rtcs_slave

// file: tb/rtcs_master.sv
// Behavioural bus master driving the serial link from the far side
`timescale 1ns/100ps
module rtcs_master (
  // Wire levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Open-drain drive, 1 = released
  output logic      o_scl_m,
  output logic      o_sda_m
);
  // ------------------------------------------------------------
  // Bit timing, quarter of a 125 ns link period
  // ------------------------------------------------------------
  localparam realtime QTR = 31.25;

  initial begin
    o_scl_m = 1'b1;
    o_sda_m = 1'b1;
  end

  // Slave may stretch the low phase, so wait for the wire, bounded
  task automatic scl_high();
    int n;
    n = 0;
    o_scl_m = 1'b1;
    // Fine polling keeps the link period close to 125 ns
    while (i_scl !== 1'b1 && n < 20000) begin
      #1;
      n++;
    end
  endtask : scl_high

  task automatic start();
    o_sda_m = 1'b1;
    #(2*QTR);
    scl_high();
    #(2*QTR);
    o_sda_m = 1'b0;
    #(2*QTR);
    o_scl_m = 1'b0;
  endtask : start

  task automatic stop();
    #QTR;
    o_sda_m = 1'b0;
    #QTR;
    scl_high();
    #(2*QTR);
    o_sda_m = 1'b1;
    #(4*QTR);
  endtask : stop

  // Data moves only in the low phase, sampled mid high phase
  task automatic clk_bit(input logic b, output logic r);
    #QTR;
    o_sda_m = b;
    #QTR;
    scl_high();
    #QTR;
    r = i_sda;
    #QTR;
    o_scl_m = 1'b0;
  endtask : clk_bit

  task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack_in);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], rx[i]);
    end
    clk_bit(ack_out, ack_in);
  endtask : xfer
endmodule : rtcs_master

// file: tb/tb.sv
// Self-checking bench of the RTC serial slave
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb
  import rtcs_pkg::*;
;
  // ------------------------------------------------------------
  // Signals, wires with pull-ups, read memory
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        wr_ready = 1'b0;
  logic        scl_m, sda_m, scl_out, scl_oe, sda_out, sda_oe, rd_sram, rd_strobe, wr_valid, busy;
  logic        stall = 1'b0;
  logic        stretch_seen = 1'b0;
  logic [7:0]  rd_addr, ptr;
  logic [7:0]  mem [2][256];
  logic [6:0]  bad;
  wire  [7:0]  rd_data = mem[rd_sram][rd_addr];
  wire         scl_w = scl_m & ~scl_oe;
  wire         sda_w = sda_m & ~sda_oe;
  rtcs_wr_type wr, exp_w;
  rtcs_wr_type exp_q[$];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          stretch_cnt = 0;
  int          n_strobe = 0;
  logic        cur_s = 1'b0;
  int unsigned r;

  always #5 clk = ~clk;

  rtcs_slave #(.FIFO_DEPTH(RTCS_FIFO_DEPTH)) u_dut (
    .i_clk(clk), .i_srst(srst), .i_scl(scl_w), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
    .i_sda_in(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_rd_sram(rd_sram),
    .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_rd_strobe(rd_strobe), .o_wr_valid(wr_valid),
    .i_wr_ready(wr_ready), .o_wr(wr), .o_busy(busy));

  rtcs_master u_mst (.i_scl(scl_w), .i_sda(sda_w), .o_scl_m(scl_m), .o_sda_m(sda_m));

  // ------------------------------------------------------------
  // Model helpers and transactions
  // ------------------------------------------------------------
  function automatic logic [6:0] id_of(input logic s);
    return s ? RTCS_ID_SRAM : RTCS_ID_CSR;
  endfunction : id_of

  function automatic logic [7:0] wrap_of(input logic s);
    return s ? RTCS_SRAM_WRAP : RTCS_CSR_WRAP;
  endfunction : wrap_of

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic       a;
    u_mst.xfer(b, 1'b1, rx, a);
    `CHK(a, exp_ack)
  endtask : send

  task automatic wr_tx(input logic s, input logic [7:0] a, input logic [7:0] d);
    exp_q.push_back('{sram: s, addr: a, data: d});
    ptr = a;
    u_mst.start();
    send({id_of(s), 1'b0}, 1'b0);
    send(a, 1'b0);
    send(d, 1'b0);
    u_mst.stop();
    repeat (8) @(posedge clk);
    `CHK(busy, 1'b0)
  endtask : wr_tx

  // Random read when rnd is set, else current-address read
  task automatic rd_tx(input logic s, input logic rnd, input logic [7:0] a, input int n);
    logic [7:0] rx;
    logic       ack;
    cur_s = s;
    n_strobe = 0;
    u_mst.start();
    if (rnd) begin
      send({id_of(s), 1'b0}, 1'b0);
      send(a, 1'b0);
      u_mst.start();
      ptr = a;
    end
    send({id_of(s), 1'b1}, 1'b0);
    for (int k = 0; k < n; k++) begin
      u_mst.xfer(8'hFF, 1'(k == n - 1), rx, ack);
      `CHK(rx, mem[s][ptr])
      ptr = (ptr == wrap_of(s)) ? RTCS_PTR_RST : ptr + RTCS_PTR_STEP;
    end
    u_mst.stop();
    repeat (8) @(posedge clk);
    `CHK(sda_oe, 1'b0)
    `CHK(n_strobe, n)
  endtask : rd_tx

  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // Write stream consumer, stalls until the slave has stretched for 50 cycles
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (exp_q.size() > 0) begin
        exp_w = exp_q.pop_front();
      end else begin
        exp_w = ~wr;
      end
      `CHK(wr, exp_w)
    end
    if (scl_oe === 1'b1) begin
      stretch_seen = 1'b1;
      stretch_cnt++;
    end
    // One strobe per loaded byte, always for the addressed target
    if (rd_strobe === 1'b1) begin
      n_strobe++;
      `CHK(rd_sram, cur_s)
    end
    // Open-drain pins may only ever pull low
    if (sda_oe === 1'b1 || scl_oe === 1'b1) begin
      `CHK({scl_out, sda_out}, 2'b00)
    end
    if (stall && stretch_cnt >= 50) begin
      stall = 1'b0;
    end
    #1 wr_ready = stall ? 1'b0 : 1'($urandom);
  end

  initial begin
    #400000;
    n_errors++;
    final_report();
  end

  initial begin
    r = $urandom(32'h462698C8);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 256; i++) begin
        mem[s][i] = 8'($urandom);
      end
    end
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    `CHK(rd_addr, RTCS_PTR_RST)
    `CHK(sda_oe, 1'b0)
    repeat (10) @(posedge clk);
    ptr = RTCS_PTR_RST;
    rd_tx(1'b0, 1'b0, 8'h00, 2);
    for (int i = 0; i < 6; i++) begin
      wr_tx(1'(i), i[0] ? 8'($urandom % 128) : 8'($urandom % 20), 8'($urandom));
    end
    rd_tx(1'b1, 1'b0, ptr, 2);
    repeat (20) @(posedge clk);
    // Four writes fill the buffer, the fifth must be held off
    stall = 1'b1;
    stretch_cnt = 0;
    stretch_seen = 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr_tx(1'($urandom), 8'($urandom % 20), 8'($urandom));
    end
    `CHK(stretch_seen, 1'b1)
    for (int i = 0; i < 4; i++) begin
      do begin
        bad = 7'($urandom);
      end while (bad == RTCS_ID_CSR || bad == RTCS_ID_SRAM);
      u_mst.start();
      send({bad, 1'($urandom)}, 1'b1);
      send(8'($urandom), 1'b1);
      u_mst.stop();
      `CHK(busy, 1'b0)
    end
    for (int i = 0; i < 4; i++) begin
      rd_tx(1'(i), 1'b1, wrap_of(1'(i)) - 8'($urandom % 3), 3 + int'($urandom % 3));
    end
    repeat (50) @(posedge clk);
    `CHK(exp_q.size(), 0)
    final_report();
  end
endmodule : tb
